// File: hdl/adjustment_data_write_gate.sv
// Gate for cyclic adjustment writes and its 16-bit response word.
// Functional notes
// - Adjustment fields live only from revision 1.1.
// - Apply bit set: adjustment outputs take effect immediately.
// - Apply bit clear: cyclic adjustment ignored, acyclic accepted.
// - Apply bit gates outputs only; inputs always update.
// - Error-free response is 0000 or 0001 hex.
// - Failure response: index low byte, then sub-index.
// - Several failures: report highest mapped position.
// - One failure never aborts the remaining writes.
// - Rejected item keeps its previous value.
// - Rejection at power-up uses nonvolatile value.
// - Writes held off while tuning runs.
// - Power-up with apply set overwrites gain sets.
`default_nettype none
module adjustment_data_write_gate
	import adjustment_data_write_gate_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [REV_W-1:0] rev_major,
	input wire logic [REV_W-1:0] rev_minor,
	input wire logic refresh,
	input wire logic [N_CH-1:0] apply_adjust,
	input wire logic auto_tuning,
	input wire logic [N_ITEMS-1:0] item_assigned,
	input wire logic [N_ITEMS-1:0][IDX_W-1:0] item_index,
	input wire logic [N_ITEMS-1:0][SUB_W-1:0] item_sub,
	input wire logic [N_ITEMS-1:0][VAL_W-1:0] out_value,
	input wire logic [N_ITEMS-1:0][VAL_W-1:0] limit_lo,
	input wire logic [N_ITEMS-1:0][VAL_W-1:0] limit_hi,
	input wire logic [N_ITEMS-1:0][VAL_W-1:0] nv_value,
	input wire logic acyc_valid,
	input wire logic [POS_W-1:0] acyc_pos,
	input wire logic [VAL_W-1:0] acyc_value,
	output logic [N_ITEMS-1:0][VAL_W-1:0] param_ff,
	output logic [RESP_W-1:0] resp_ff,
	output logic resp_valid_ff,
	output logic rev_ok_ff
);

	logic rev_seen_ff;
	logic power_up_ff;
	logic nxt_rev_seen;
	logic nxt_rev_ok;
	logic nxt_power_up;
	logic [N_ITEMS-1:0][VAL_W-1:0] nxt_param;
	logic [RESP_W-1:0] nxt_resp;
	logic nxt_resp_valid;
	logic apply_any;
	logic write_en;
	logic [N_ITEMS-1:0] fail;
	logic [N_ITEMS-1:0] accept;

	// Any single channel bit opens the gate; the controller must clear all.
	assign apply_any = |apply_adjust;
	// Tuning suspends cyclic writes; they resume on a later refresh.
	assign write_en = refresh && rev_ok_ff && apply_any
		&& !auto_tuning;

	// Every mapped item is checked on its own, so one bad value cannot
	// stop the others.
	genvar g;
	generate
		for (g = 0; g < N_ITEMS; g++) begin : g_item
			assign fail[g] = write_en && item_assigned[g]
				&& (out_value[g] < limit_lo[g]
				|| out_value[g] > limit_hi[g]);
			assign accept[g] = write_en && item_assigned[g]
				&& !fail[g];
		end
	endgenerate

	// The revision strap is caught on the first edge after reset release.
	always_comb begin
		nxt_rev_seen = 1'b1;
		nxt_rev_ok = rev_ok_ff;
		if (!rev_seen_ff) begin
			nxt_rev_ok = (rev_major > REV_MAJOR_MIN)
				|| (rev_major == REV_MAJOR_MIN
				&& rev_minor >= REV_MINOR_MIN);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rev_seen_ff <= 1'b0;
			rev_ok_ff <= 1'b0;
		end else begin
			rev_seen_ff <= nxt_rev_seen;
			rev_ok_ff <= nxt_rev_ok;
		end
	end

	always_comb begin
		nxt_param = param_ff;
		nxt_power_up = power_up_ff;
		nxt_resp = resp_ff;
		nxt_resp_valid = refresh;
		// Acyclic writes ignore the apply bit; a cyclic write in the same
		// cycle to the same item takes precedence.
		if (acyc_valid) begin
			nxt_param[acyc_pos] = acyc_value;
		end
		if (refresh) begin
			if (power_up_ff) begin
				nxt_param = nv_value;
				nxt_power_up = 1'b0;
			end
			for (int i = 0; i < N_ITEMS; i++) begin
				if (accept[i]) begin
					nxt_param[i] = out_value[i];
				end
			end
			if (!rev_ok_ff) begin
				nxt_resp = RESP_OK_OFF;
			end else if (apply_any) begin
				nxt_resp = RESP_OK_ON;
			end else begin
				nxt_resp = RESP_OK_OFF;
			end
			// Ascending scan lets the highest mapped failure win.
			for (int i = 0; i < N_ITEMS; i++) begin
				if (fail[i]) begin
					nxt_resp = {item_index[i][IDX_LO_MSB:0],
						item_sub[i]};
				end
			end
		end
	end

	// Rejected items are not written by the cyclic data; they keep the old value, or take nv_value on the power-up refresh.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			param_ff <= '0;
			power_up_ff <= 1'b1;
			resp_ff <= RESP_OK_OFF;
			resp_valid_ff <= 1'b0;
		end else begin
			param_ff <= nxt_param;
			power_up_ff <= nxt_power_up;
			resp_ff <= nxt_resp;
			resp_valid_ff <= nxt_resp_valid;
		end
	end

	// Helper: highest failing position of the refresh, for the checks.
	logic any_fail;
	logic [POS_W-1:0] top_fail;
	always_comb begin
		any_fail = 1'b0;
		top_fail = '0;
		for (int i = 0; i < N_ITEMS; i++) begin
			if (fail[i]) begin
				any_fail = 1'b1;
				top_fail = POS_W'(i);
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_clean_refresh;
		refresh && rev_ok_ff && !any_fail;
	endsequence

	sequence s_fail_refresh;
		refresh && any_fail;
	endsequence

	a_resp_ok_off: assert property (
		s_clean_refresh and (!apply_any) |=> resp_ff == RESP_OK_OFF
		&& resp_valid_ff)
		else $error("Clean refresh with apply clear gave wrong code.");

	a_resp_ok_on: assert property (
		s_clean_refresh and (apply_any) |=> resp_ff == RESP_OK_ON)
		else $error("Clean refresh with apply set gave wrong code.");

	a_resp_fail_code: assert property (
		s_fail_refresh |=> resp_ff[RESP_HI_MSB:RESP_HI_LSB]
		== $past(item_index[top_fail][IDX_LO_MSB:0])
		&& resp_ff[SUB_W-1:0] == $past(item_sub[top_fail]))
		else $error("Failure code does not name the failing item.");

	a_highest_fail: assert property (
		refresh && fail[N_ITEMS-1] |=> resp_ff
		== {$past(item_index[N_ITEMS-1][IDX_LO_MSB:0]),
		$past(item_sub[N_ITEMS-1])})
		else $error("Failure code is not from the highest position.");

	a_gate_closed: assert property (
		refresh && !apply_any && !acyc_valid && !power_up_ff
		|=> param_ff == $past(param_ff))
		else $error("Cyclic data changed a value with apply clear.");

	a_tuning_hold: assert property (
		refresh && auto_tuning && !acyc_valid && !power_up_ff
		|=> $stable(param_ff) && !$past(any_fail))
		else $error("Value applied while tuning was running.");

	a_apply_value: assert property (
		refresh && accept[0] |=> param_ff[0] == $past(out_value[0]))
		else $error("Accepted item was not applied at once.");

	a_reject_keep: assert property (
		refresh && fail[N_ITEMS-1] && !power_up_ff && !acyc_valid
		|=> param_ff[N_ITEMS-1] == $past(param_ff[N_ITEMS-1]))
		else $error("Rejected item lost its previous value.");

	a_powerup_nv: assert property (
		refresh && power_up_ff && fail[0] && !acyc_valid
		|=> param_ff[0] == $past(nv_value[0]) && !power_up_ff)
		else $error("Power-up rejection did not fall back to stored.");

	a_rev_reserved: assert property (
		refresh && !rev_ok_ff |=> resp_ff == RESP_OK_OFF)
		else $error("Reserved revision produced an adjustment response.");

	a_continue_rest: assert property (
		refresh && fail[N_ITEMS-1] && accept[0]
		|=> param_ff[0] == $past(out_value[0]))
		else $error("A failure stopped the remaining writes.");

	a_valid_pulse: assert property (
		refresh |=> resp_valid_ff)
		else $error("Refresh gave no response strobe.");

	a_valid_idle: assert property (
		!refresh |=> !resp_valid_ff)
		else $error("Response strobe without a refresh.");

	a_resp_stands: assert property (
		!refresh |=> $stable(resp_ff))
		else $error("Response word moved between refreshes.");

	a_param_stands: assert property (
		!refresh && !acyc_valid |=> $stable(param_ff))
		else $error("A value changed with no write at all.");

	a_acyc_accept: assert property (
		acyc_valid && !refresh
		|=> param_ff[$past(acyc_pos)] == $past(acyc_value))
		else $error("Acyclic write was not taken.");

	a_report_always: assert property (
		acyc_valid && !refresh && !apply_any
		|=> param_ff[$past(acyc_pos)] == $past(acyc_value))
		else $error("Reported value not updated with apply clear.");

	a_rev_hold: assert property (
		refresh && !rev_ok_ff && !power_up_ff && !acyc_valid
		|=> $stable(param_ff))
		else $error("Old revision took cyclic adjustment data.");

	a_strap_fixed: assert property (
		rev_seen_ff |=> $stable(rev_ok_ff))
		else $error("Revision decision changed after capture.");

	a_powerup_once: assert property (
		refresh |=> !power_up_ff)
		else $error("Power-up load still pending after a refresh.");

	a_tuning_noerr: assert property (
		refresh && auto_tuning && rev_ok_ff
		|=> resp_ff[RESP_HI_MSB:RESP_HI_LSB] == '0)
		else $error("Tuning hold was reported as a failure.");

	sequence s_held_refresh;
		refresh && auto_tuning && apply_any && rev_ok_ff;
	endsequence

	sequence s_resume_refresh;
		refresh && !auto_tuning && accept[0];
	endsequence

	a_tuning_resume: assert property (
		s_held_refresh ##1 !refresh [*2] ##1 s_resume_refresh
		|=> param_ff[0] == $past(out_value[0]))
		else $error("Held value was not applied after tuning.");

	// Per-item checks, so that one bad position cannot hide behind
	// a neighbour that happens to hold the same value.
	generate
		for (g = 0; g < N_ITEMS; g++) begin : g_chk
			a_item_apply: assert property (
				refresh && accept[g]
				|=> param_ff[g] == $past(out_value[g]))
				else $error("Accepted item was not written.");

			a_reject_hold: assert property (
				refresh && fail[g] && !power_up_ff
				&& !acyc_valid
				|=> $stable(param_ff[g]))
				else $error("Rejected item changed its value.");

			a_powerup_gain: assert property (
				refresh && power_up_ff && accept[g]
				|=> param_ff[g] == $past(out_value[g]))
				else $error("Power-up ignored the output field.");
		end
	endgenerate

endmodule
`default_nettype wire

// File: hdl/adjustment_data_write_gate_pkg.sv
// Constants shared by the adjustment data write gate.
`default_nettype none
package adjustment_data_write_gate_pkg;
	localparam int N_CH = 4;
	localparam int N_ITEMS = 8;
	localparam int POS_W = 3;
	localparam int VAL_W = 16;
	localparam int IDX_W = 16;
	localparam int SUB_W = 8;
	localparam int RESP_W = 16;
	localparam int REV_W = 4;
	localparam logic [REV_W-1:0] REV_MAJOR_MIN = 4'h1;
	localparam logic [REV_W-1:0] REV_MINOR_MIN = 4'h1;
	localparam logic [RESP_W-1:0] RESP_OK_OFF = 16'h0000;
	localparam logic [RESP_W-1:0] RESP_OK_ON = 16'h0001;
	localparam int RESP_HI_LSB = 8;
	localparam int RESP_HI_MSB = 15;
	localparam int IDX_LO_MSB = 7;
endpackage
`default_nettype wire

// File: sim/ctrl_model.sv
// Controller-side model that raises refreshes and channel apply bits.
`default_nettype none
module ctrl_model
	import adjustment_data_write_gate_pkg::*;
(
	input wire logic go,
	input wire logic en,
	input wire logic [1:0] ch,
	output logic refresh,
	output logic [N_CH-1:0] apply_adjust
);
	timeunit 1ns;
	timeprecision 1ps;
	assign refresh = go;
	// One channel's bit enables writes; stopping clears all bits.
	assign apply_adjust = en ? N_CH'(1) << ch : '0;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the adjustment data write gate.
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top
	import adjustment_data_write_gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, go = 0, en = 0, auto_tuning = 0;
	logic acyc_valid = 0, rok = 0, first = 0;
	logic [1:0] ch = 0;
	logic [REV_W-1:0] rev_major = 0, rev_minor = 0;
	logic [N_ITEMS-1:0] item_assigned = 0;
	logic [N_ITEMS-1:0][IDX_W-1:0] item_index = '0;
	logic [N_ITEMS-1:0][SUB_W-1:0] item_sub = '0;
	logic [N_ITEMS-1:0][VAL_W-1:0] out_value = '0, limit_lo, limit_hi;
	logic [N_ITEMS-1:0][VAL_W-1:0] nv_value, param_ff, exp_p;
	logic [POS_W-1:0] acyc_pos = 0;
	logic [VAL_W-1:0] acyc_value = 0, v0 = 0;
	logic [RESP_W-1:0] resp_ff, exp_r;
	logic refresh, resp_valid_ff, rev_ok_ff;
	logic [N_CH-1:0] apply_adjust;
	int error_cnt = 0, checks = 0, seed = 32'h9FAF, mode = 0;
	ctrl_model u_ctrl_model (.go, .en, .ch, .refresh, .apply_adjust);
	adjustment_data_write_gate u_adjustment_data_write_gate (.clk, .reset_n,
		.rev_major, .rev_minor, .refresh, .apply_adjust, .auto_tuning,
		.item_assigned, .item_index, .item_sub, .out_value, .limit_lo,
		.limit_hi, .nv_value, .acyc_valid, .acyc_pos, .acyc_value,
		.param_ff, .resp_ff, .resp_valid_ff, .rev_ok_ff);
	initial forever #2 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_rst(input logic [3:0] maj, input logic [3:0] mnr);
		@(posedge clk);
		reset_n <= 0;
		rev_major <= maj;
		rev_minor <= mnr;
		repeat (5) @(posedge clk);
		reset_n <= 1;
		repeat (2) @(posedge clk);
		#1;
		rok = maj > 1 || (maj == 1 && mnr >= 1);
		first = 1;
		exp_p = '0;
		`CHK(rev_ok_ff, rok)
		`CHK(param_ff, exp_p)
	endtask
	task automatic do_ref(input logic e, input logic t);
		@(posedge clk);
		en <= e;
		auto_tuning <= t;
		ch <= 2'($random(seed));
		go <= 1;
		if (mode != 1) begin
			if (mode == 3)
				item_assigned <= '1;
			else
				item_assigned <= 8'($random(seed));
			for (int i = 0; i < N_ITEMS; i++) begin
				if (mode == 2)
					out_value[i] <= param_ff[i];
				else if (mode == 3 && i == 0)
					out_value[i] <= v0;
				else if (mode == 3 && i == N_ITEMS - 1)
					out_value[i] <= 16'hFFFF;
				else
					out_value[i] <= 16'($random(seed));
				item_index[i] <= 16'($random(seed));
				item_sub[i] <= 8'($random(seed));
			end
		end
		@(posedge clk);
		go <= 0;
		if (first)
			exp_p = nv_value;
		first = 0;
		exp_r = (rok && e) ? RESP_OK_ON : RESP_OK_OFF;
		for (int i = 0; i < N_ITEMS; i++) begin
			if (rok && e && !t && item_assigned[i]) begin
				if (out_value[i] >= limit_lo[i] && out_value[i] <= limit_hi[i])
					exp_p[i] = out_value[i];
				else
					exp_r = {item_index[i][IDX_LO_MSB:0], item_sub[i]};
			end
		end
		#1;
		`CHK(resp_valid_ff, 1'b1)
		`CHK(resp_ff, exp_r)
		`CHK(param_ff, exp_p)
		@(posedge clk);
		#1;
		`CHK(resp_valid_ff, 1'b0)
	endtask
	task automatic do_acyc();
		@(posedge clk);
		acyc_valid <= 1;
		en <= 1'($random(seed));
		acyc_pos <= 3'($random(seed));
		acyc_value <= 16'($random(seed));
		@(posedge clk);
		acyc_valid <= 0;
		exp_p[acyc_pos] = acyc_value;
		#1;
		`CHK(param_ff, exp_p)
	endtask
	initial begin
		for (int i = 0; i < N_ITEMS; i++) begin
			limit_lo[i] = 16'h2000;
			limit_hi[i] = 16'hD000;
			nv_value[i] = 16'($random(seed));
		end
		do_rst(4'h1, 4'h0);
		repeat (2) do_ref(1'b1, 1'b0);
		$display("test old revision done");
		do_rst(4'h1, 4'h1);
		mode = 3;
		do_ref(1'b1, 1'b0);
		mode = 2;
		do_ref(1'b1, 1'b0);
		$display("test power-up done");
		v0 = 16'h4000;
		mode = 3;
		do_ref(1'b1, 1'b1);
		mode = 1;
		do_ref(1'b1, 1'b0);
		mode = 0;
		$display("test tuning hold done");
		repeat (100) do_ref(1'($random(seed)), (3'($random(seed)) == 0));
		$display("test random refresh done");
		repeat (8) do_acyc();
		$display("test acyclic done");
		stop_test();
	end
	// Generous bound: the whole sequence needs well under 1000 cycles.
	initial begin
		#40000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
